/* ulpitc_top.sv */
// ulpitc_top: interface-control register of a ulpi transceiver with its link-side access
// assumes: ulpi_stp and ulpi_data_i are driven by the link on ulpi_clk edges,
// fault_pin is asynchronous, core-side strobes and phy_power_n come from clk logic
`timescale 1ns/10ps
`default_nettype none

module ulpitc_top
#(
  parameter int STP_STUCK_CYCLES = ulpitc_pkg::STP_STUCK_CYC
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,

  // ulpi link clock
  input wire logic ulpi_clk,

  // ulpi pins
  input wire logic ulpi_stp,
  input wire logic [7:0] ulpi_data_i,
  output logic [7:0] ulpi_data_o,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,

  // interface guard
  output logic stp_pullup_en,
  output logic data_pulldown_en,
  output logic link_released,

  // overcurrent indicator
  input wire logic fault_pin,
  output logic overcurrent_out,
  output logic indicator_bypass_qualify,

  // power and serial modes
  input wire logic phy_power_n,
  input wire logic three_wire_exit,
  input wire logic six_wire_exit,
  output logic phy_power_restore,
  output logic clock_power_en,
  output logic three_wire_serial_sel,
  output logic six_wire_serial_sel
);

  import ulpitc_pkg::*;

  localparam logic [STP_CNT_W-1:0] STP_STUCK_CNT = STP_CNT_W'(STP_STUCK_CYCLES);

  // effect of a register write at one of the three addresses
  function automatic logic [7:0] ctrl_apply(
    input logic [7:0] old_val,
    input logic [5:0] addr,
    input logic [7:0] wdata
  );
    logic [7:0] res;
    res = old_val;
    if (addr == ADDR_WRITE) begin
      res = wdata; // RULE2
    end else if (addr == ADDR_SET) begin
      res = old_val | wdata; // RULE16
    end else if (addr == ADDR_CLEAR) begin
      res = old_val & ~wdata; // RULE16
    end
    return res & CTRL_IMPL_MASK; // RULE17
  endfunction : ctrl_apply

  // address decode shared by read and write commands
  function automatic logic addr_is_ours(input logic [5:0] addr);
    return (addr == ADDR_WRITE) || (addr == ADDR_SET) || (addr == ADDR_CLEAR);
  endfunction : addr_is_ours

  // link clock domain: reset and events from the core

  logic ulpi_rst_n;
  logic three_tog_r;
  logic six_tog_r;
  logic [1:0] exit_tog_s;
  logic [1:0] exit_tog_d_r;

  ulpitc_sync #(.WIDTH(1)) u_sync_rst (
    .clk(ulpi_clk),
    .async_i(rst_n),
    .sync_o(ulpi_rst_n)
  );

  ulpitc_sync #(.WIDTH(2)) u_sync_exit (
    .clk(ulpi_clk),
    .async_i({three_tog_r, six_tog_r}),
    .sync_o(exit_tog_s)
  );

  wire three_exit_seen = exit_tog_s[1] ^ exit_tog_d_r[1];
  wire six_exit_seen = exit_tog_s[0] ^ exit_tog_d_r[0];

  always_ff @(posedge ulpi_clk) begin
    if (!ulpi_rst_n) begin
      exit_tog_d_r <= 2'h0;
    end else begin
      exit_tog_d_r <= exit_tog_s;
    end
  end

  // link clock domain: register command sequencer

  ulpitc_state_e state_r;
  ulpitc_state_e state_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [5:0] cmd_addr_r;
  logic cmd_read_r;
  logic [7:0] wdata_r;
  logic [7:0] data_o_r;

  wire [1:0] cmd_type = ulpi_data_i[CMD_TYPE_HI:CMD_TYPE_LO];
  wire [5:0] cmd_addr = ulpi_data_i[CMD_ADDR_HI:0];
  wire cmd_is_reg = (cmd_type == CMD_REG_WRITE) || (cmd_type == CMD_REG_READ);
  wire cmd_seen = (state_r == ST_IDLE) && !ulpi_stp && cmd_is_reg && addr_is_ours(cmd_addr);
  wire write_fire = (state_r == ST_WSTOP) && ulpi_stp;
  wire [7:0] ctrl_written = ctrl_apply(ctrl_r, cmd_addr_r, wdata_r);

  // serial bits dropped by the block when the mode is left; wins over a write
  wire [7:0] auto_clear = {6'h00, three_exit_seen, six_exit_seen}; // RULE12 RULE14

  assign ctrl_nxt = (write_fire ? ctrl_written : ctrl_r) & ~auto_clear;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_seen) begin
          state_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cmd_read_r) begin
          state_nxt = ST_TURN;
        end else begin
          state_nxt = ST_WDATA;
        end
      end
      ST_WDATA: begin
        state_nxt = ST_WSTOP;
      end
      ST_WSTOP: begin
        if (ulpi_stp) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TURN: begin
        state_nxt = ST_RDATA;
      end
      ST_RDATA: begin
        state_nxt = ST_TURNB;
      end
      ST_TURNB: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ulpi_clk) begin
    if (!ulpi_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ulpi_clk) begin
    if (!ulpi_rst_n) begin
      ctrl_r <= CTRL_RESET; // RULE16
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // command capture; the link holds the command byte until nxt
  always_ff @(posedge ulpi_clk) begin
    if (!ulpi_rst_n) begin
      cmd_addr_r <= 6'h00;
      cmd_read_r <= 1'b0;
    end else if (cmd_seen) begin
      cmd_addr_r <= cmd_addr;
      cmd_read_r <= (cmd_type == CMD_REG_READ);
    end
  end

  always_ff @(posedge ulpi_clk) begin
    if (!ulpi_rst_n) begin
      wdata_r <= 8'h00;
    end else if (state_r == ST_WDATA) begin
      wdata_r <= ulpi_data_i;
    end
  end

  // read data is the same at all three addresses
  always_ff @(posedge ulpi_clk) begin
    if (!ulpi_rst_n) begin
      data_o_r <= 8'h00;
    end else if (state_r == ST_TURN) begin
      data_o_r <= ctrl_r & CTRL_IMPL_MASK; // RULE2 RULE17
    end
  end

  assign ulpi_nxt = (state_r == ST_CMD) || (state_r == ST_WDATA);
  assign ulpi_dir = (state_r == ST_TURN) || (state_r == ST_RDATA);
  assign ulpi_data_oe = (state_r == ST_RDATA);
  assign ulpi_data_o = data_o_r;

  // core clock domain: inputs brought across

  logic [7:0] ctrl_raw_s;
  logic [7:0] ctrl_raw_d_r;
  logic [7:0] ctrl_cfg_r;
  logic stp_s;
  logic fault_s;

  ulpitc_sync #(.WIDTH(8)) u_sync_ctrl (
    .clk(clk),
    .async_i(ctrl_r),
    .sync_o(ctrl_raw_s)
  );

  // the copied word is taken only after two equal samples, so bits of two writes never mix
  always_ff @(posedge clk) begin
    ctrl_raw_d_r <= ctrl_raw_s;
    ctrl_cfg_r <= !rst_n ? CTRL_RESET : (ctrl_raw_s == ctrl_raw_d_r) ? ctrl_raw_s : ctrl_cfg_r;
  end

  ulpitc_sync #(.WIDTH(2)) u_sync_pins (
    .clk(clk),
    .async_i({ulpi_stp, fault_pin}),
    .sync_o({stp_s, fault_s})
  );

  // exit strobes become toggles so the link domain cannot miss them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      three_tog_r <= 1'b0;
      six_tog_r <= 1'b0;
    end else begin
      three_tog_r <= three_tog_r ^ three_wire_exit; // RULE12
      six_tog_r <= six_tog_r ^ six_wire_exit; // RULE14
    end
  end

  // core clock domain: interface guard

  logic [STP_CNT_W-1:0] stp_cnt_r;
  logic [STP_CNT_W-1:0] stp_cnt_nxt;
  logic stp_d_r;
  logic stp_pullup_r;
  logic pulldown_r;
  logic released_r;

  wire guard_on = !ctrl_cfg_r[BIT_GUARD_DIS]; // RULE5
  wire stp_stuck = (stp_cnt_r == STP_STUCK_CNT);

  // a normal stop lasts one link cycle; longer means nobody drives stp
  assign stp_cnt_nxt = (!guard_on || !stp_s) ? '0 :
                       (stp_stuck ? stp_cnt_r : stp_cnt_r + 1'b1); // RULE4

  // in low power a long stp is the wake-up request, not a released link
  wire released_nxt = guard_on && stp_stuck && phy_power_n; // RULE3 RULE4

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stp_cnt_r <= '0;
    end else begin
      stp_cnt_r <= stp_cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stp_pullup_r <= 1'b0;
      pulldown_r <= 1'b0;
      released_r <= 1'b0;
    end else begin
      stp_pullup_r <= guard_on; // RULE3 RULE5
      pulldown_r <= released_nxt; // RULE3 RULE5
      released_r <= released_nxt; // RULE4
    end
  end

  assign stp_pullup_en = stp_pullup_r;
  assign data_pulldown_en = pulldown_r;
  assign link_released = released_r;

  // core clock domain: low-power exit

  logic restore_r;

  wire wake_req = stp_s && !stp_d_r && !phy_power_n;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stp_d_r <= 1'b0;
      restore_r <= 1'b0;
    end else begin
      stp_d_r <= stp_s;
      restore_r <= wake_req; // RULE15
    end
  end

  assign phy_power_restore = restore_r;

  // core clock domain: overcurrent indicator

  logic overcurrent_r;
  logic bypass_r;

  // the supply-valid comparator is deliberately not part of this path
  wire overcurrent_nxt = fault_s ^ ctrl_cfg_r[BIT_INVERT]; // RULE7 RULE8

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overcurrent_r <= 1'b0;
      bypass_r <= 1'b0;
    end else begin
      overcurrent_r <= overcurrent_nxt; // RULE8
      bypass_r <= ctrl_cfg_r[BIT_BYPASS]; // RULE6
    end
  end

  assign overcurrent_out = overcurrent_r;
  assign indicator_bypass_qualify = bypass_r;

  // core clock domain: serial modes and clock power

  logic three_sel_r;
  logic six_sel_r;
  logic clk_pwr_r;

  // both set together is undefined; each select simply follows its bit
  wire three_sel_nxt = ctrl_cfg_r[BIT_THREE]; // RULE1 RULE11
  wire six_sel_nxt = ctrl_cfg_r[BIT_SIX]; // RULE1 RULE13
  wire serial_mode = three_sel_nxt || six_sel_nxt;

  // outside serial mode, or in low power, the keep-alive bit is ignored
  wire clk_pwr_nxt = phy_power_n && (serial_mode ? ctrl_cfg_r[BIT_KEEPALIVE] : 1'b1); // RULE9 RULE10

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      three_sel_r <= 1'b0;
      six_sel_r <= 1'b0;
      clk_pwr_r <= 1'b0;
    end else begin
      three_sel_r <= three_sel_nxt; // RULE11
      six_sel_r <= six_sel_nxt; // RULE13
      clk_pwr_r <= clk_pwr_nxt; // RULE9 RULE10
    end
  end

  assign three_wire_serial_sel = three_sel_r;
  assign six_wire_serial_sel = six_sel_r;
  assign clock_power_en = clk_pwr_r;

endmodule : ulpitc_top

`default_nettype wire

/* ulpitc_pkg.sv */
// ulpitc_pkg: constants, bit positions and types for the ulpi interface-control block
// assumes: register commands arrive on the ulpi link clock, core-side logic runs on clk
// Summary of operation
// (RULE1) The link sets at most one alternative interface field at a time, else behaviour is undefined.
// (RULE2) The register reads at 07h, 08h and 09h, is written at 07h, bit-set at 08h, bit-cleared at 09h.
// (RULE3) With the guard enabled stp has a weak pull-up, and a stp stuck high adds data pull-downs; here they are added only while the phy is powered.
// (RULE4) With the guard enabled the block flags when the link has stopped driving stp; here the flag is raised only while the phy is powered.
// (RULE5) Setting the guard-disable bit removes the stp pull-up and the data pull-downs.
// (RULE6) The link always writes one to the indicator bypass bit; zero is not supported.
// (RULE7) The overcurrent output never mixes in the internal host supply-valid comparator.
// (RULE8) The invert bit at one inverts the fault input to form the output, at zero passes it as is.
// (RULE9) The clock keep-alive bit matters only in a serial mode and while the phy is powered.
// (RULE10) In a serial mode the clock stays powered when the keep-alive bit is one, off when zero.
// (RULE11) The three-wire bit at one moves full and low speed traffic onto a 3-bit serial interface.
// (RULE12) The block clears the three-wire bit itself when three-wire serial mode is left.
// (RULE13) The six-wire bit at one moves full and low speed traffic onto a 6-bit serial interface.
// (RULE14) The block clears the six-wire bit itself when six-wire serial mode is left.
// (RULE15) The link raises stp to leave low power, and the phy power bit is then restored to one.
// (RULE16) Reset clears the register; set and clear addresses act on the bits written as one.
// (RULE17) Reserved bits four and two read as zero and steer nothing.

package ulpitc_pkg;

  // ulpi register command byte
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;
  localparam int CMD_TYPE_HI = 7;
  localparam int CMD_TYPE_LO = 6;
  localparam int CMD_ADDR_HI = 5;

  // register addresses
  localparam logic [5:0] ADDR_WRITE = 6'h07;
  localparam logic [5:0] ADDR_SET = 6'h08;
  localparam logic [5:0] ADDR_CLEAR = 6'h09;

  // register layout
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'heb;
  localparam int BIT_GUARD_DIS = 7;
  localparam int BIT_BYPASS = 6;
  localparam int BIT_INVERT = 5;
  localparam int BIT_KEEPALIVE = 3;
  localparam int BIT_THREE = 1;
  localparam int BIT_SIX = 0;

  // timing on clk
  localparam int CLK_MHZ = 25;
  localparam int STP_STUCK_NS = 200;
  localparam int STP_STUCK_CYC = (STP_STUCK_NS * CLK_MHZ + 999) / 1000;
  localparam int STP_CNT_W = 4;

  // link-side register access sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_WDATA,
    ST_WSTOP,
    ST_TURN,
    ST_RDATA,
    ST_TURNB
  } ulpitc_state_e;

endpackage : ulpitc_pkg

/* ulpitc_sync.sv */
// ulpitc_sync: two-stage level synchroniser, one per bit
// assumes: inputs are levels or toggles that stay put for at least two destination edges
`timescale 1ns/10ps
`default_nettype none

module ulpitc_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input wire logic clk,
  // source level and synchronised copy
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk) begin
    meta_r <= async_i;
    sync_r <= meta_r;
  end

  assign sync_o = sync_r;

endmodule : ulpitc_sync

`default_nettype wire

/* ulpitc_monitor.sv */
// ulpitc_monitor: port-level assertions for ulpitc_top
// assumes: bound into ulpitc_top, rst_n serves both clock domains
`timescale 1ns/10ps
`default_nettype none

module ulpitc_monitor #(
  parameter int STP_STUCK_CYCLES = 5
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ulpi_clk,
  // ulpi pins
  input wire logic ulpi_stp,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic ulpi_data_oe,
  // core side
  input wire logic stp_pullup_en,
  input wire logic data_pulldown_en,
  input wire logic link_released,
  input wire logic phy_power_n,
  input wire logic three_wire_exit,
  input wire logic six_wire_exit,
  input wire logic phy_power_restore,
  input wire logic clock_power_en,
  input wire logic three_wire_serial_sel,
  input wire logic six_wire_serial_sel
);
  read_walk_a: assert property (
    @(posedge ulpi_clk) disable iff (!rst_n)
    $rose(ulpi_dir) |=> ulpi_dir && ulpi_data_oe ##1 !ulpi_dir && !ulpi_data_oe)
    else $error("read turnaround broken");
  ack_next_a: assert property (
    @(posedge ulpi_clk) disable iff (!rst_n) $rose(ulpi_nxt) |=> ulpi_nxt != ulpi_dir)
    else $error("command ack not followed by data or turnaround");
  oe_dir_a: assert property (
    @(posedge ulpi_clk) disable iff (!rst_n) ulpi_data_oe |-> ulpi_dir && !ulpi_nxt)
    else $error("data driven outside read");
  released_same_a: assert property (
    @(posedge clk) disable iff (!rst_n) link_released == data_pulldown_en)
    else $error("release flag differs from pull-down");
  pulldown_guard_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    data_pulldown_en |-> stp_pullup_en || $past(stp_pullup_en))
    else $error("pull-down with guard off");
  pulldown_cause_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(data_pulldown_en) |-> $past(ulpi_stp, 3) && $past(ulpi_stp, 6) && $past(phy_power_n))
    else $error("pull-down without stuck stp");
  pulldown_drop_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    data_pulldown_en && !ulpi_stp |-> ##[1:6] !data_pulldown_en)
    else $error("pull-down held after stp low");
  three_exit_a: assert property (
    @(posedge clk) disable iff (!rst_n) three_wire_exit |-> ##[1:30] !three_wire_serial_sel)
    else $error("three-wire bit not cleared");
  six_exit_a: assert property (
    @(posedge clk) disable iff (!rst_n) six_wire_exit |-> ##[1:30] !six_wire_serial_sel)
    else $error("six-wire bit not cleared");
  clock_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n) clock_power_en |-> $past(phy_power_n))
    else $error("clock powered in low power");
  clock_plain_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(phy_power_n) && !three_wire_serial_sel && !six_wire_serial_sel
    && !$past(three_wire_serial_sel) && !$past(six_wire_serial_sel) |-> clock_power_en)
    else $error("clock off outside serial mode");
  restore_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    phy_power_restore |-> !$past(phy_power_n) ##1 !phy_power_restore)
    else $error("power restore pulse wrong");
endmodule : ulpitc_monitor

bind ulpitc_top ulpitc_monitor #(.STP_STUCK_CYCLES(STP_STUCK_CYCLES)) u_monitor (
  .clk(clk), .rst_n(rst_n), .ulpi_clk(ulpi_clk), .ulpi_stp(ulpi_stp), .ulpi_dir(ulpi_dir),
  .ulpi_nxt(ulpi_nxt), .ulpi_data_oe(ulpi_data_oe), .stp_pullup_en(stp_pullup_en),
  .data_pulldown_en(data_pulldown_en), .link_released(link_released),
  .phy_power_n(phy_power_n), .three_wire_exit(three_wire_exit), .six_wire_exit(six_wire_exit),
  .phy_power_restore(phy_power_restore), .clock_power_en(clock_power_en),
  .three_wire_serial_sel(three_wire_serial_sel), .six_wire_serial_sel(six_wire_serial_sel)
);
`default_nettype wire

/* ulpitc_link_model.sv */
// ulpitc_link_model: ulpi link controller issuing register commands
// assumes: block outputs change on ulpi_clk rising edges
`timescale 1ns/10ps
`default_nettype none

module ulpitc_link_model (
  // link clock
  input wire logic ulpi_clk,
  // block outputs
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic ulpi_data_oe,
  input wire logic [7:0] ulpi_data_o,
  // link outputs
  output logic ulpi_stp,
  output logic [7:0] ulpi_data_i
);
  logic nxt_s;
  logic oe_s;
  logic [7:0] rd_s;
  initial begin
    ulpi_stp = 1'b0;
    ulpi_data_i = 8'h00;
  end
  // settled copies, used at the next rising edge
  always @(negedge ulpi_clk) begin
    nxt_s = ulpi_nxt;
    oe_s = ulpi_data_oe;
    rd_s = ulpi_data_o;
  end
  task automatic wait_nxt(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(posedge ulpi_clk);
      ok = nxt_s;
    end
  endtask : wait_nxt
  task automatic reg_write(input logic [5:0] addr, input logic [7:0] data, output logic ok);
    @(posedge ulpi_clk);
    ulpi_data_i <= {2'h2, addr};
    wait_nxt(ok);
    if (ok) begin
      ulpi_data_i <= data;
      wait_nxt(ok);
      ulpi_stp <= 1'b1;
      @(posedge ulpi_clk);
      ulpi_stp <= 1'b0;
    end
    ulpi_data_i <= 8'h00;
  endtask : reg_write
  task automatic reg_read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
    @(posedge ulpi_clk);
    ulpi_data_i <= {2'h3, addr};
    wait_nxt(ok);
    data = 8'h00;
    if (ok) begin
      // released bus shows the inverse of the last value
      ulpi_data_i <= ~{2'h3, addr};
      ok = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
        @(posedge ulpi_clk);
        ok = oe_s;
        data = rd_s;
      end
    end
    ulpi_data_i <= 8'h00;
  endtask : reg_read
  task automatic stp_level(input logic v);
    @(posedge ulpi_clk);
    ulpi_stp <= v;
  endtask : stp_level
endmodule : ulpitc_link_model
`default_nettype wire

/* test_ulpi_phy_interface_control.sv */
// test_ulpi_phy_interface_control: self-checking bench for ulpitc_top
// assumes: link model on the ulpi side, clk 40 ns, ulpi_clk 160 ns
`timescale 1ns/10ps
`default_nettype none

module test_ulpi_phy_interface_control;
  import ulpitc_pkg::*;
  logic clk, rst_n, ulpi_clk, ulpi_stp, ulpi_data_oe, ulpi_dir, ulpi_nxt, fault_pin;
  logic stp_pullup_en, data_pulldown_en, link_released, overcurrent_out, phy_power_n;
  logic indicator_bypass_qualify, three_wire_exit, six_wire_exit, phy_power_restore;
  logic clock_power_en, three_wire_serial_sel, six_wire_serial_sel, ok;
  logic [7:0] ulpi_data_i, ulpi_data_o, model_r, rd, d;
  logic [5:0] a;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'ha771;

  ulpitc_top DUT (.clk(clk), .rst_n(rst_n), .ulpi_clk(ulpi_clk), .ulpi_stp(ulpi_stp),
    .ulpi_data_i(ulpi_data_i), .ulpi_data_o(ulpi_data_o), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .stp_pullup_en(stp_pullup_en),
    .data_pulldown_en(data_pulldown_en), .link_released(link_released),
    .fault_pin(fault_pin), .overcurrent_out(overcurrent_out),
    .indicator_bypass_qualify(indicator_bypass_qualify), .phy_power_n(phy_power_n),
    .three_wire_exit(three_wire_exit), .six_wire_exit(six_wire_exit),
    .phy_power_restore(phy_power_restore), .clock_power_en(clock_power_en),
    .three_wire_serial_sel(three_wire_serial_sel), .six_wire_serial_sel(six_wire_serial_sel));
  ulpitc_link_model link (.ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_oe(ulpi_data_oe), .ulpi_data_o(ulpi_data_o), .ulpi_stp(ulpi_stp),
    .ulpi_data_i(ulpi_data_i));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    ulpi_clk = 1'b0;
    #7;
    forever #80 ulpi_clk = ~ulpi_clk;
  end
  // whole run needs well under 300 us
  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  function automatic logic [7:0] apply(input logic [7:0] o, input logic [5:0] ad,
                                       input logic [7:0] dt);
    logic [7:0] v;
    v = (ad == ADDR_SET) ? (o | dt) : (ad == ADDR_CLEAR) ? (o & ~dt) : dt;
    return v & CTRL_IMPL_MASK;
  endfunction : apply
  task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
    link.reg_write(ad, dt, ok);
    check(ok, 1'b1);
    model_r = apply(model_r, ad, dt);
  endtask : wr
  task automatic rd_chk(input logic [5:0] ad);
    link.reg_read(ad, rd, ok);
    check(ok, 1'b1);
    check(rd, model_r);
  endtask : rd_chk
  task automatic outs_chk;
    repeat (24) @(negedge clk);
    check(three_wire_serial_sel, model_r[BIT_THREE]);
    check(six_wire_serial_sel, model_r[BIT_SIX]);
    check(indicator_bypass_qualify, model_r[BIT_BYPASS]);
    check(stp_pullup_en, !model_r[BIT_GUARD_DIS]);
    check(overcurrent_out, fault_pin ^ model_r[BIT_INVERT]);
    check(clock_power_en, phy_power_n & (model_r[1:0] != 2'h0 ? model_r[3] : 1'b1));
  endtask : outs_chk

  initial begin
    rst_n = 1'b0;
    fault_pin = 1'b0;
    phy_power_n = 1'b1;
    three_wire_exit = 1'b0;
    six_wire_exit = 1'b0;
    model_r = CTRL_RESET;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (24) @(negedge clk);
    for (int i = 7; i <= 9; i++) rd_chk(6'(i));
    outs_chk;
    check(data_pulldown_en, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      fault_pin = 1'($random(seed));
      phy_power_n = 1'($random(seed));
      a = ADDR_WRITE + 6'($unsigned($random(seed)) % 3);
      d = 8'($random(seed));
      d[BIT_BYPASS] = (a != ADDR_CLEAR);
      if ((apply(model_r, a, d) & 8'h03) == 8'h03) d[1:0] = 2'h0;
      wr(a, d);
      rd_chk(ADDR_WRITE + 6'($unsigned($random(seed)) % 3));
      outs_chk;
    end
    $display("random test done");
    link.reg_write(6'h0a, 8'hff, ok);
    check(ok, 1'b0);
    link.reg_read(6'h06, rd, ok);
    check(ok, 1'b0);
    rd_chk(ADDR_WRITE);
    $display("unmapped test done");
    phy_power_n = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_WRITE, k ? 8'h41 : 8'h4a);
      outs_chk;
      if (k) begin
        six_wire_exit = 1'b1;
      end else begin
        three_wire_exit = 1'b1;
      end
      @(negedge clk);
      three_wire_exit = 1'b0;
      six_wire_exit = 1'b0;
      model_r = model_r & 8'hfc;
      outs_chk;
      rd_chk(ADDR_CLEAR);
    end
    $display("serial exit test done");
    for (int k = 0; k < 2; k++) begin
      wr(k ? ADDR_SET : ADDR_CLEAR, 8'h80);
      link.stp_level(1'b1);
      outs_chk;
      check(data_pulldown_en, !k);
      check(link_released, !k);
      link.stp_level(1'b0);
      repeat (8) @(negedge clk);
      check(data_pulldown_en, 1'b0);
    end
    $display("guard test done");
    phy_power_n = 1'b0;
    rd = 8'h00;
    fork
      begin
        link.stp_level(1'b1);
        link.stp_level(1'b0);
      end
      repeat (40) begin
        @(negedge clk);
        rd = rd + 8'(phy_power_restore);
      end
    join
    check(rd, 8'h01);
    $display("wake test done");
    phy_power_n = 1'b1;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    model_r = CTRL_RESET;
    repeat (24) @(negedge clk);
    rd_chk(ADDR_SET);
    outs_chk;
    check(data_pulldown_en, 1'b0);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : test_ulpi_phy_interface_control
`default_nettype wire
